// >>> tb/ssmt_axi_master.sv
`timescale 1ns/10ps

module ssmt_axi_master (
  input wire logic clk_sys, // clock
  output logic [7:0] awaddr = 8'h00, // aw addr
  output logic awvalid = 1'b0, // aw valid
  input wire logic awready, // aw ready
  output logic [31:0] wdata = 32'h0, // w data
  output logic [3:0] wstrb = 4'h0, // w strobes
  output logic wvalid = 1'b0, // w valid
  input wire logic wready, // w ready
  input wire logic [1:0] bresp, // b resp
  input wire logic bvalid, // b valid
  output logic bready = 1'b0, // b ready
  output logic [7:0] araddr = 8'h00, // ar addr
  output logic arvalid = 1'b0, // ar valid
  input wire logic arready, // ar ready
  input wire logic [31:0] rdata, // r data
  input wire logic [1:0] rresp, // r resp
  input wire logic rvalid, // r valid
  output logic rready = 1'b0 // r ready
);
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : bus_wr
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : bus_rd
endmodule : ssmt_axi_master

// >>> tb/ssmt_exec_assertions.sv
`timescale 1ns/10ps
`include "ssmt_defines.svh"

module ssmt_exec_chk (
  input wire logic clk_sys, // clock
  input wire logic reset, // sync reset
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic [1:0] s_axi_bresp, // b resp
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_rdata, // r data
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready, // r ready
  input wire logic cpu_clk_halt, // cpu halt
  input wire logic sys_clk_halt, // sys halt
  input wire logic int_service // wake pulse
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
  property p_b_after; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid; endproperty
  a_b_after: assert property (p_b_after) else $error("write response late");
  property p_r_after; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_after: assert property (p_r_after) else $error("read data late");
  property p_halt_pair; cpu_clk_halt == sys_clk_halt; endproperty
  a_halt_pair: assert property (p_halt_pair) else $error("halt outputs differ");
  property p_halt_rise; $rose(cpu_clk_halt) |-> $past(s_axi_bvalid, 4); endproperty
  a_halt_rise: assert property (p_halt_rise) else $error("halt not four cycles after command");
  // a reset also drops the halts, so the edge just after reset is excluded
  property p_halt_fall; $fell(cpu_clk_halt) && !$past(reset) |-> int_service; endproperty
  a_halt_fall: assert property (p_halt_fall) else $error("stop left without interrupt");
  property p_wake; int_service |-> $past(cpu_clk_halt) && !cpu_clk_halt ##1 !int_service; endproperty
  a_wake: assert property (p_wake) else $error("bad wake pulse");
  property p_stop_refuse;
    $rose(s_axi_bvalid) && $past(cpu_clk_halt, 2) && cpu_clk_halt |-> s_axi_bresp == `SSMT_RESP_SLVERR;
  endproperty
  a_stop_refuse: assert property (p_stop_refuse) else $error("write taken in stop");
  c_stop: cover property ($rose(cpu_clk_halt));
  c_wake: cover property (int_service);
  c_err: cover property (s_axi_bvalid && s_axi_bresp == `SSMT_RESP_SLVERR);
endmodule : ssmt_exec_chk

// >>> tb/testbench.sv
`timescale 1ns/10ps
`include "ssmt_defines.svh"

module testbench;
  localparam logic [1:0] ok = `SSMT_RESP_OKAY;
  localparam logic [1:0] se = `SSMT_RESP_SLVERR;
  localparam logic [7:0] fl_a = `SSMT_OFF_FLAGS;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic ext_int = 1'b0;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic cpu_clk_halt, sys_clk_halt, int_service;
  int err_count = 0;
  int comparisons = 0;

  always #5 clk_sys = ~clk_sys;

  ssmt_axi_master m (.clk_sys(clk_sys), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));

  ssmt_exec dut (.clk_sys(clk_sys), .reset(reset), .ext_int(ext_int), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .cpu_clk_halt(cpu_clk_halt), .sys_clk_halt(sys_clk_halt), .int_service(int_service));

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [7:0] ra(input logic [3:0] n);
    return `SSMT_OFF_REGS + {2'b00, n, 2'b00};
  endfunction : ra

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    m.bus_wr(a, d, r);
    chk(r, er);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    m.bus_rd(a, d, r);
    chk(r, er);
    chk(d, e);
  endtask : rd

  // issue one instruction and wait, bounded, until busy clears
  task automatic ex(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2);
    logic [31:0] d;
    logic [1:0] r;
    wr(`SSMT_OFF_CMD, {8'h00, b2, b1, op}, ok);
    d = 32'h1;
    for (int i = 0; i < 10 && d[0] !== 1'b0; i++) m.bus_rd(`SSMT_OFF_STATUS, d, r);
    chk(d[0], 1'b0);
  endtask : ex

  // expected {result, flags}; kind 0 subtract, 1 mask probe, 2 right shift
  function automatic logic [15:0] model(input logic [1:0] k, input logic [7:0] d, s, f);
    logic [7:0] r;
    r = (k == 2'd0) ? d - s : (k == 2'd1) ? ~d & s : {d[7], d[7:1]};
    if (k == 2'd0) return {r, d < s, r == 8'h00, r[7], d[7] != s[7] && r[7] == s[7], 1'b1, d[3:0] < s[3:0], 2'b00};
    if (k == 2'd1) return {d, f[7], r == 8'h00, r[7], 1'b0, f[3:2], 2'b00};
    return {r, d[0], r == 8'h00, r[7], 1'b0, f[3:2], 2'b00};
  endfunction : model

  task automatic t_misc;
    rd(fl_a, 32'h0, ok);
    rd(8'h3c, 32'h0, se);
    wr(8'h3c, 32'h1, se);
    wr(`SSMT_OFF_CMD, 32'h72, se);
    rd(`SSMT_OFF_STATUS, 32'h0c, ok);
    wr(fl_a, 32'h7c, ok);
    ex(8'hdf, 8'h00, 8'h00);
    rd(fl_a, 32'hfc, ok);
    // a six-cycle subtract is still running when the second command lands
    wr(`SSMT_OFF_CMD, 32'h010126, ok);
    wr(`SSMT_OFF_CMD, 32'h010126, se);
    rd(`SSMT_OFF_STATUS, 32'h38, ok);
    $display("t_misc done");
  endtask : t_misc

  task automatic t_shift;
    logic [7:0] v[3];
    logic [15:0] e;
    v = '{8'h9a, 8'h01, 8'hbd};
    for (int i = 0; i < 3; i++) begin
      wr(ra(3), {24'h0, v[i]}, ok);
      wr(ra(2), 32'h03, ok);
      wr(fl_a, 32'h0c, ok);
      ex(i == 1 ? 8'hd1 : 8'hd0, i == 1 ? 8'h02 : 8'h03, 8'h00);
      e = model(2'd2, v[i], 8'h00, 8'h0c);
      rd(ra(3), e[15:8], ok);
      rd(fl_a, e[7:0], ok);
    end
    $display("t_shift done");
  endtask : t_shift

  task automatic t_alu(input logic [7:0] base, input logic [7:0] d, input logic [7:0] s, input logic [7:0] im);
    logic [7:0] sv[5];
    logic [7:0] b1[5];
    logic [15:0] e;
    sv = '{8'h03, s, 8'h03, s, im};
    b1 = '{8'h12, 8'h12, 8'h02, 8'h02, 8'h01};
    for (int i = 0; i < 5; i++) begin
      wr(ra(1), {24'h0, d}, ok);
      wr(ra(2), 32'h03, ok);
      wr(ra(3), {24'h0, s}, ok);
      wr(fl_a, 32'hac, ok);
      ex(base + 8'(i), b1[i], i < 2 ? 8'h00 : (i == 4 ? im : 8'h01));
      e = model({1'b0, base[6]}, d, sv[i], 8'hac);
      rd(ra(1), e[15:8], ok);
      rd(fl_a, e[7:0], ok);
      rd(ra(3), s, ok);
    end
    $display("t_alu %h done", base);
  endtask : t_alu

  task automatic t_stop;
    wr(ra(5), 32'ha5, ok);
    wr(fl_a, 32'h54, ok);
    wr(`SSMT_OFF_CMD, 32'h7f, ok);
    for (int i = 0; i < 10 && cpu_clk_halt !== 1'b1; i++) @(posedge clk_sys);
    chk(cpu_clk_halt, 1'b1);
    wr(ra(5), 32'h3c, se);
    rd(fl_a, 32'h54, ok);
    repeat (20) @(posedge clk_sys);
    chk(sys_clk_halt, 1'b1);
    ext_int <= 1'b1;
    for (int i = 0; i < 12 && int_service !== 1'b1; i++) @(posedge clk_sys);
    chk(int_service, 1'b1);
    chk(cpu_clk_halt, 1'b0);
    ext_int <= 1'b0;
    rd(ra(5), 32'ha5, ok);
    rd(`SSMT_OFF_STATUS, 32'h50, ok);
    ex(8'hdf, 8'h00, 8'h00);
    rd(fl_a, 32'hd4, ok);
    $display("t_stop done");
  endtask : t_stop

  initial begin
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    t_misc();
    t_shift();
    t_alu(8'h22, 8'h21, 8'h0a, 8'h90);
    t_alu(8'h62, 8'h47, 8'hc0, 8'h34);
    t_stop();
    test_done();
  end

  // the tests need well under a thousand cycles; this leaves wide margin
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    test_done();
  end
endmodule : testbench

bind ssmt_exec ssmt_exec_chk u_chk (.clk_sys(clk_sys), .reset(reset), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .cpu_clk_halt(cpu_clk_halt),
  .sys_clk_halt(sys_clk_halt), .int_service(int_service));

// >>> verilog/ssmt_alu.sv
`timescale 1ns/10ps
`include "ssmt_defines.svh"

module ssmt_alu (
  input wire ssmt_pkg::ssmt_opk_t opk, // operation class
  input wire logic [7:0] dst, // destination operand
  input wire logic [7:0] src, // source operand or mask
  input wire logic [7:0] flags_in, // flags before the instruction
  output logic [7:0] result, // value to write back
  output logic wr_dst, // write result into destination
  output logic [7:0] flags_out // flags after the instruction
);

  logic [8:0] sum;
  logic [4:0] low_sum;
  logic [7:0] probe;

  always_comb begin
    // two's complement add: carry out of 8 bits means no borrow
    sum = {1'b0, dst} + {1'b0, ~src} + 9'h001;
    low_sum = {1'b0, dst[3:0]} + {1'b0, ~src[3:0]} + 5'h01;
    probe = ~dst & src;
    result = dst;
    wr_dst = 1'b0;
    flags_out = flags_in;
    unique case (opk)
      ssmt_pkg::OPK_SETC: begin
        flags_out[`SSMT_FL_C] = 1'b1;
      end
      ssmt_pkg::OPK_ASHR: begin
        result = {dst[7], dst[7:1]};
        wr_dst = 1'b1;
        flags_out[`SSMT_FL_C] = dst[0];
        flags_out[`SSMT_FL_Z] = (result == 8'h00);
        flags_out[`SSMT_FL_S] = result[7];
        flags_out[`SSMT_FL_V] = 1'b0;
      end
      ssmt_pkg::OPK_SUB: begin
        result = sum[7:0];
        wr_dst = 1'b1;
        flags_out[`SSMT_FL_C] = ~sum[8];
        flags_out[`SSMT_FL_Z] = (sum[7:0] == 8'h00);
        flags_out[`SSMT_FL_S] = sum[7];
        flags_out[`SSMT_FL_V] = (dst[7] != src[7]) && (sum[7] == src[7]);
        flags_out[`SSMT_FL_D] = 1'b1;
        flags_out[`SSMT_FL_H] = ~low_sum[4];
      end
      ssmt_pkg::OPK_PROBE: begin
        // nothing written back, only flags move
        flags_out[`SSMT_FL_Z] = (probe == 8'h00);
        flags_out[`SSMT_FL_S] = probe[7];
        flags_out[`SSMT_FL_V] = 1'b0;
      end
      default: begin
        flags_out = flags_in;
      end
    endcase
  end

endmodule : ssmt_alu

// >>> verilog/ssmt_defines.svh
`ifndef SSMT_DEFINES_SVH
`define SSMT_DEFINES_SVH

// opcodes
`define SSMT_FORCE_FLAG_ONE_OP 8'hdf
`define SSMT_SIGN_KEEPING_RIGHT_SHIFT_OP_R 8'hd0
`define SSMT_SIGN_KEEPING_RIGHT_SHIFT_OP_IR 8'hd1
`define SSMT_STOP_OP 8'h7f
`define SSMT_SUB_OP_RR 8'h22
`define SSMT_SUB_OP_RIR 8'h23
`define SSMT_SUB_OP_RRF 8'h24
`define SSMT_SUB_OP_RIRF 8'h25
`define SSMT_SUB_OP_RIM 8'h26
`define SSMT_INVERTED_MASK_PROBE_OP_RR 8'h62
`define SSMT_INVERTED_MASK_PROBE_OP_RIR 8'h63
`define SSMT_INVERTED_MASK_PROBE_OP_RRF 8'h64
`define SSMT_INVERTED_MASK_PROBE_OP_RIRF 8'h65
`define SSMT_INVERTED_MASK_PROBE_OP_RIM 8'h66

// cycle counts and byte lengths
`define SSMT_CYC_SHORT 3'h4
`define SSMT_CYC_LONG 3'h6
`define SSMT_LEN_1 2'h1
`define SSMT_LEN_2 2'h2
`define SSMT_LEN_3 2'h3

// flag bit positions in the flag byte
`define SSMT_FL_C 7
`define SSMT_FL_Z 6
`define SSMT_FL_S 5
`define SSMT_FL_V 4
`define SSMT_FL_D 3
`define SSMT_FL_H 2
`define SSMT_FLAGS_MASK 8'hfc
`define SSMT_FLAGS_RESET 8'h00

// register map (byte addresses)
`define SSMT_OFF_CMD 8'h00
`define SSMT_OFF_FLAGS 8'h04
`define SSMT_OFF_STATUS 8'h08
`define SSMT_OFF_REGS 8'h40
`define SSMT_NREGS 16
`define SSMT_REG_RESET 8'h00

// status bit positions
`define SSMT_ST_BUSY 0
`define SSMT_ST_STOP 1
`define SSMT_ST_ILLEGAL 2
`define SSMT_ST_REJECT 3
`define SSMT_ST_LEN_LO 4
`define SSMT_ST_WAKE 6

// axi responses
`define SSMT_RESP_OKAY 2'h0
`define SSMT_RESP_SLVERR 2'h2

`endif

// >>> verilog/ssmt_exec.sv
// The AXI4-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/10ps
`include "ssmt_defines.svh"

// Function
// - set-carry (DF, 1 byte, 4 cycles) forces carry to one.
// - set-carry leaves zero, sign, overflow, decimal-adjust, half-carry untouched.
// - arithmetic right shift, D0 register or D1 indirect, 2 bytes, 4 cycles.
// - bit 7 kept and copied to bit 6; old bit 0 goes to carry.
// - shift flags: carry from bit 0, zero, sign, overflow cleared, D/H kept.
// - stop (7F, 1 byte, 4 cycles) halts both clocks, enters stop mode, no flags.
// - stop mode keeps every register and port register unchanged.
// - stop mode ends only by external reset or external interrupt input.
// - subtract adds two's complement of source; destination gets difference.
// - subtract opcodes 22..26 with their lengths, modes and cycle counts.
// - subtract carry means borrow; zero and sign follow the result.
// - subtract overflow: opposite operand signs and result sign equals source sign.
// - subtract forces decimal-adjust; half-carry set on low nibble borrow.
// - mask probe ANDs inverted destination with the source mask.
// - mask probe writes nothing back; zero set when the result is zero.
// - mask probe sign from bit 7, overflow cleared, C/D/H kept.
// - mask probe opcodes 62..66 with their lengths, modes and cycle counts.

module ssmt_exec (
  input wire logic clk_sys, // 100 MHz system clock
  input wire logic reset, // synchronous, active high
  input wire logic ext_int, // external interrupt pin, asynchronous
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic cpu_clk_halt, // cpu clock stopped
  output logic sys_clk_halt, // system clock stopped
  output logic int_service // one-cycle pulse: enter interrupt service
);

  ssmt_pkg::ssmt_state_t state_q;
  ssmt_pkg::ssmt_dec_t dec_q;
  logic [7:0] byte2_q;
  logic [7:0] byte3_q;
  logic [2:0] cnt_q;
  logic [7:0] regs_q [`SSMT_NREGS];
  logic [7:0] flags_q;
  logic illegal_q;
  logic reject_q;
  logic wake_q;
  logic cpu_halt_q;
  logic sys_halt_q;
  logic int_service_q;

  // axi slave state
  logic aw_have_q;
  logic w_have_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // interrupt pin synchroniser
  logic int_s1_q;
  logic int_s2_q;
  logic int_s3_q;
  logic int_level_q;

  // operand fetch and alu
  logic [3:0] dst_idx;
  logic [7:0] dst_val;
  logic [7:0] src_val;
  logic [7:0] alu_res;
  logic alu_wr;
  logic [7:0] alu_flags;

  logic do_write;
  logic wr_cmd;
  logic wr_flags;
  logic wr_reg;
  logic wr_ok;
  logic cmd_accept;
  logic commit;
  logic stopped;

  function automatic logic [3:0] reg_idx(input logic [7:0] a);
    // the slice holds sixteen registers, upper address bits fold away
    return a[3:0];
  endfunction : reg_idx

  function automatic logic is_reg_addr(input logic [7:0] a);
    return (a[7:6] == 2'(`SSMT_OFF_REGS >> 6)) && (a[1:0] == 2'h0);
  endfunction : is_reg_addr

  assign stopped = (state_q == ssmt_pkg::ST_STOP);
  assign commit = (state_q == ssmt_pkg::ST_EXEC) && (cnt_q == 3'h0);

  // operand fetch per addressing mode
  always_comb begin
    dst_idx = reg_idx(byte2_q);
    dst_val = 8'h00;
    src_val = 8'h00;
    unique case (dec_q.mode)
      ssmt_pkg::AM_RR: begin
        dst_idx = byte2_q[7:4];
        src_val = regs_q[byte2_q[3:0]];
      end
      ssmt_pkg::AM_RIR: begin
        dst_idx = byte2_q[7:4];
        src_val = regs_q[reg_idx(regs_q[byte2_q[3:0]])];
      end
      ssmt_pkg::AM_RRF: begin
        dst_idx = reg_idx(byte3_q);
        src_val = regs_q[reg_idx(byte2_q)];
      end
      ssmt_pkg::AM_RIRF: begin
        dst_idx = reg_idx(byte3_q);
        src_val = regs_q[reg_idx(regs_q[reg_idx(byte2_q)])];
      end
      ssmt_pkg::AM_RIM: begin
        dst_idx = reg_idx(byte2_q);
        src_val = byte3_q;
      end
      ssmt_pkg::AM_DST_IR: begin
        dst_idx = reg_idx(regs_q[reg_idx(byte2_q)]);
      end
      default: begin
        dst_idx = reg_idx(byte2_q);
      end
    endcase
    dst_val = regs_q[dst_idx];
  end

  ssmt_alu u_alu (
    .opk(dec_q.opk),
    .dst(dst_val),
    .src(src_val),
    .flags_in(flags_q),
    .result(alu_res),
    .wr_dst(alu_wr),
    .flags_out(alu_flags)
  );

  // ---- axi write side ----
  assign do_write = aw_have_q && w_have_q && !bvalid_q;
  // in stop mode every write is refused so the registers and flags stay frozen
  assign wr_ok = !stopped;
  assign wr_cmd = do_write && (awaddr_q == `SSMT_OFF_CMD);
  assign wr_flags = do_write && wr_ok && (awaddr_q == `SSMT_OFF_FLAGS) && wstrb_q[0];
  assign wr_reg = do_write && wr_ok && is_reg_addr(awaddr_q) && wstrb_q[0];
  assign cmd_accept = wr_cmd && (state_q == ssmt_pkg::ST_IDLE) && dec_new_q_legal();

  function automatic logic dec_new_q_legal();
    return ssmt_pkg::ssmt_decode(wdata_q[7:0]).legal;
  endfunction : dec_new_q_legal

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      aw_have_q <= 1'b0;
      awaddr_q <= 8'h00;
    end else if (s_axi_awvalid && !aw_have_q) begin
      aw_have_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (do_write) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      w_have_q <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else if (s_axi_wvalid && !w_have_q) begin
      w_have_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (do_write) begin
      w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bvalid_q <= 1'b0;
      bresp_q <= `SSMT_RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= (wr_flags || wr_reg || cmd_accept) ? `SSMT_RESP_OKAY : `SSMT_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ---- axi read side ----
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `SSMT_RESP_OKAY;
    end else if (rvalid_q) begin
      arready_q <= 1'b0;
      if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= `SSMT_RESP_OKAY;
      rdata_q <= 32'h00000000;
      if (s_axi_araddr == `SSMT_OFF_FLAGS) begin
        rdata_q[7:0] <= flags_q;
      end else if (s_axi_araddr == `SSMT_OFF_STATUS) begin
        rdata_q[`SSMT_ST_BUSY] <= (state_q == ssmt_pkg::ST_EXEC);
        rdata_q[`SSMT_ST_STOP] <= stopped;
        rdata_q[`SSMT_ST_ILLEGAL] <= illegal_q;
        rdata_q[`SSMT_ST_REJECT] <= reject_q;
        rdata_q[`SSMT_ST_LEN_LO +: 2] <= dec_q.len;
        rdata_q[`SSMT_ST_WAKE] <= wake_q;
      end else if (is_reg_addr(s_axi_araddr)) begin
        rdata_q[7:0] <= regs_q[s_axi_araddr[5:2]];
      end else if (s_axi_araddr != `SSMT_OFF_CMD) begin
        rresp_q <= `SSMT_RESP_SLVERR;
      end
    end else begin
      arready_q <= s_axi_arvalid;
    end
  end

  // ---- interrupt pin: three flops, change taken when stages two and three agree ----
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      int_s1_q <= 1'b0;
      int_s2_q <= 1'b0;
      int_s3_q <= 1'b0;
      int_level_q <= 1'b0;
    end else begin
      int_s1_q <= ext_int;
      int_s2_q <= int_s1_q;
      int_s3_q <= int_s2_q;
      if (int_s2_q == int_s3_q) begin
        int_level_q <= int_s3_q;
      end
    end
  end

  // ---- sequencing ----
  // reset is the only other way out of stop; it must outlast oscillator start-up
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q <= ssmt_pkg::ST_IDLE;
      cnt_q <= 3'h0;
      dec_q <= '{legal: 1'b0, opk: ssmt_pkg::OPK_NONE, mode: ssmt_pkg::AM_NONE, cycles: 3'h0, len: 2'h0};
      byte2_q <= 8'h00;
      byte3_q <= 8'h00;
    end else begin
      unique case (state_q)
        ssmt_pkg::ST_IDLE: begin
          if (cmd_accept) begin
            state_q <= ssmt_pkg::ST_EXEC;
            dec_q <= ssmt_pkg::ssmt_decode(wdata_q[7:0]);
            cnt_q <= ssmt_pkg::ssmt_decode(wdata_q[7:0]).cycles - 3'h1;
            byte2_q <= wdata_q[15:8];
            byte3_q <= wdata_q[23:16];
          end
        end
        ssmt_pkg::ST_EXEC: begin
          if (cnt_q != 3'h0) begin
            cnt_q <= cnt_q - 3'h1;
          end else if (dec_q.opk == ssmt_pkg::OPK_STOP) begin
            state_q <= ssmt_pkg::ST_STOP;
          end else begin
            state_q <= ssmt_pkg::ST_IDLE;
          end
        end
        ssmt_pkg::ST_STOP: begin
          if (int_level_q) begin
            state_q <= ssmt_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cpu_halt_q <= 1'b0;
      sys_halt_q <= 1'b0;
      int_service_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      int_service_q <= 1'b0;
      if (commit && dec_q.opk == ssmt_pkg::OPK_STOP) begin
        cpu_halt_q <= 1'b1;
        sys_halt_q <= 1'b1;
        wake_q <= 1'b0;
      end else if (stopped && int_level_q) begin
        cpu_halt_q <= 1'b0;
        sys_halt_q <= 1'b0;
        int_service_q <= 1'b1;
        wake_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      illegal_q <= 1'b0;
      reject_q <= 1'b0;
    end else if (wr_cmd) begin
      illegal_q <= !dec_new_q_legal();
      reject_q <= !cmd_accept;
    end
  end

  // flags: the executing instruction wins over a software write in the same cycle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      flags_q <= `SSMT_FLAGS_RESET;
    end else if (commit) begin
      flags_q <= alu_flags & `SSMT_FLAGS_MASK;
    end else if (wr_flags) begin
      flags_q <= wdata_q[7:0] & `SSMT_FLAGS_MASK;
    end
  end

  // register file; the mask probe and set-carry never raise alu_wr
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      for (int i = 0; i < `SSMT_NREGS; i++) begin
        regs_q[i] <= `SSMT_REG_RESET;
      end
    end else begin
      if (wr_reg) regs_q[awaddr_q[5:2]] <= wdata_q[7:0];
      if (commit && alu_wr) regs_q[dst_idx] <= alu_res;
    end
  end

  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready = !w_have_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign cpu_clk_halt = cpu_halt_q;
  assign sys_clk_halt = sys_halt_q;
  assign int_service = int_service_q;

endmodule : ssmt_exec

// >>> verilog/ssmt_pkg.sv
`include "ssmt_defines.svh"

package ssmt_pkg;

  typedef enum logic [2:0] {
    OPK_NONE, OPK_SETC, OPK_ASHR, OPK_STOP, OPK_SUB, OPK_PROBE
  } ssmt_opk_t;

  typedef enum logic [2:0] {
    AM_NONE, AM_RR, AM_RIR, AM_RRF, AM_RIRF, AM_RIM, AM_DST_R, AM_DST_IR
  } ssmt_mode_t;

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_STOP} ssmt_state_t;

  typedef struct packed {
    logic legal;
    ssmt_opk_t opk;
    ssmt_mode_t mode;
    logic [2:0] cycles;
    logic [1:0] len;
  } ssmt_dec_t;

  function automatic ssmt_dec_t ssmt_decode(input logic [7:0] opc);
    ssmt_dec_t d;
    d = '{legal: 1'b1, opk: OPK_NONE, mode: AM_NONE, cycles: `SSMT_CYC_LONG, len: `SSMT_LEN_3};
    case (opc)
      `SSMT_FORCE_FLAG_ONE_OP: begin
        d.opk = OPK_SETC;
        d.cycles = `SSMT_CYC_SHORT;
        d.len = `SSMT_LEN_1;
      end
      `SSMT_SIGN_KEEPING_RIGHT_SHIFT_OP_R, `SSMT_SIGN_KEEPING_RIGHT_SHIFT_OP_IR: begin
        d.opk = OPK_ASHR;
        d.mode = opc[0] ? AM_DST_IR : AM_DST_R;
        d.cycles = `SSMT_CYC_SHORT;
        d.len = `SSMT_LEN_2;
      end
      `SSMT_STOP_OP: begin
        d.opk = OPK_STOP;
        d.cycles = `SSMT_CYC_SHORT;
        d.len = `SSMT_LEN_1;
      end
      `SSMT_SUB_OP_RR, `SSMT_SUB_OP_RIR, `SSMT_SUB_OP_RRF, `SSMT_SUB_OP_RIRF, `SSMT_SUB_OP_RIM,
      `SSMT_INVERTED_MASK_PROBE_OP_RR, `SSMT_INVERTED_MASK_PROBE_OP_RIR,
      `SSMT_INVERTED_MASK_PROBE_OP_RRF, `SSMT_INVERTED_MASK_PROBE_OP_RIRF,
      `SSMT_INVERTED_MASK_PROBE_OP_RIM: begin
        d.opk = (opc[7:4] == 4'h2) ? OPK_SUB : OPK_PROBE;
        unique case (opc[3:0])
          4'h2: begin
            d.mode = AM_RR;
            d.cycles = `SSMT_CYC_SHORT;
            d.len = `SSMT_LEN_2;
          end
          4'h3: begin
            d.mode = AM_RIR;
            d.len = `SSMT_LEN_2;
          end
          4'h4: d.mode = AM_RRF;
          4'h5: d.mode = AM_RIRF;
          default: d.mode = AM_RIM;
        endcase
      end
      default: d.legal = 1'b0;
    endcase
    return d;
  endfunction : ssmt_decode

endpackage : ssmt_pkg
